/* File: testbench/ebu_emu_model.sv */
// model: emulator pod driving the request pin and the lower-address comparator
`timescale 1ns/1ps
module ebu_emu_model
(
  input wire logic clk, // system clock
  input wire logic hold_low, // keep the request pin low
  input wire logic [15:0] lo_addr, // lower bus address
  input wire logic [15:0] lo_cmp, // lower compare value
  input wire logic as_n, // address strobe
  output logic debug_irq_input, // request pin
  output logic ext_hit // comparator result for the break pin
);
  always_ff @(posedge clk)
    debug_irq_input <= ~hold_low;
  // deasserted outside strobed cycles so no stale match leaks into the next cycle
  assign ext_hit = ~as_n & (lo_addr == lo_cmp);
endmodule // ebu_emu_model

/* File: testbench/emulation_breakpoint_unit_tb.sv */
// testbench: directed scenarios for the emulation breakpoint unit
`timescale 1ns/1ps
module emulation_breakpoint_unit_tb;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hold_low = 1'b1;
  logic boot_req = 1'b1;
  logic [15:0] lo_cmp = 16'h0000;
  logic [15:0] core_data = 16'h5A3C; // every memory read returns this word; monitor reads keep its upper byte
  ebu_pkg::ebu_bus_t bus = '{32'h0, 3'h0, 1'b1, 1'b1, 1'b0};
  ebu_pkg::ebu_ctrl_t ctl = '0; // single, prog, cmp, busirq, hardmap
  ebu_pkg::ebu_cyc_t cc = 4'hF;
  logic [31:0] acmp = 32'h0;
  logic [31:0] amsk = 32'h0;
  logic [2:0] w1c = 3'h0;
  logic pin_in, hit, brk_o, brk_oe, emu, boot_cs, mon_cs, mon8, ack, irq, vld, pd, dbg;
  logic [15:0] dout;
  logic [31:0] vec;
  logic [2:0] stat;
  int n_fail = 0;
  int checks_done = 0;
  int ticks = 0;
  always #2.5 clk = ~clk;
  assign pin_in = brk_oe ? brk_o : hit;
  ebu_emu_model emu_u (.clk(clk), .hold_low(hold_low), .lo_addr(bus.addr[15:0]),
    .lo_cmp(lo_cmp), .as_n(bus.as_n), .debug_irq_input(dbg), .ext_hit(hit));
  ebu_unit dut_u (.clk(clk), .nrst(nrst), .debug_irq_input(dbg), .bus(bus),
    .core_data(core_data), .emulation_control_reg(ctl), .addr_compare_bits(acmp),
    .addr_mask_bits(amsk), .cyc_cmp(cc), .status_w1c(w1c), .boot_cs_req(boot_req),
    .breakpoint_signal_i(pin_in), .breakpoint_signal_o(brk_o),
    .breakpoint_signal_oe(brk_oe), .emu_mode(emu), .boot_chip_select(boot_cs),
    .monitor_chip_select(mon_cs), .monitor_port_8bit(mon8), .monitor_ack(ack),
    .data_to_core(dout), .level_seven_interrupt(irq), .l7_vector(vec),
    .l7_vector_valid(vld), .emulation_status_reg(stat), .program_data(pd));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // strobe goes idle for a clock first so every call is a fresh cycle start
  task automatic rd(input logic [31:0] a, input logic [2:0] fc, input logic vf);
    @(posedge clk);
    bus.as_n <= 1'b1;
    @(posedge clk);
    bus <= '{a, fc, 1'b1, 1'b0, vf};
    @(negedge clk);
  endtask
  task automatic rst(input logic low);
    @(posedge clk);
    hold_low <= low;
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    hold_low <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic clr(input logic [2:0] b);
    @(posedge clk);
    w1c <= b;
    @(posedge clk);
    w1c <= 3'h0;
    repeat (2) @(negedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_boot;
    logic [15:0] exp [4];
    exp = '{16'hFFFC, 16'hFFFC, 16'hFFFC, 16'h0020};
    rst(1'b1);
    @(negedge clk);
    chk("emu_mode", 1'b1, emu);
    chk("stat_boot", 3'h0, stat);
    for (int i = 0; i < 4; i++)
    begin
      rd(32'(2 * i), 3'h6, 1'b1);
      chk("boot_cs", 1'b0, boot_cs);
      @(negedge clk);
      chk("reset_word", exp[i], dout);
    end
  endtask
  task automatic s_monitor;
    logic [31:0] a [6];
    a = '{32'hFFFC0000, 32'hFFFCFFFF, 32'hFFFD0000, 32'hFFFDFFFF, 32'hFFFE0000, 32'hFFFBFFFF};
    for (int i = 0; i < 6; i++)
    begin
      rd(a[i], 3'h5, 1'b0);
      chk("mon_cs", i < 4, mon_cs);
      chk("mon_8bit", i < 4, mon8);
      chk("mon_ack", i < 2, ack);
    end
    rd(32'hFFFC0000, 3'h5, 1'b0);
    @(negedge clk);
    chk("mon_lane", 16'h5A00, dout);
  endtask
  task automatic s_pin;
    @(posedge clk);
    hold_low <= 1'b1;
    repeat (6) @(negedge clk);
    chk("stat_pin", 3'h1, stat);
    chk("irq", 1'b1, irq);
    chk("vector", ebu_pkg::L7_VECTOR, vec);
    chk("vec_valid", 1'b1, vld);
    clr(3'h1);
    repeat (8) @(negedge clk);
    chk("stat_clr", 3'h0, stat);
    chk("irq_clr", 1'b0, irq);
    @(posedge clk);
    hold_low <= 1'b0;
  endtask
  task automatic s_exec;
    @(posedge clk);
    ctl <= 5'b11100;
    acmp <= 32'h00001230;
    amsk <= 32'h0000000F;
    rd(32'h28, 3'h5, 1'b0);
    rd(32'h2A, 3'h5, 1'b0);
    chk("plain_pin", 1'b0, brk_o & brk_oe);
    repeat (2) @(negedge clk);
    chk("plain_vec", 1'b0, stat[1]);
    rd(32'h0000123B, 3'h5, 1'b0);
    chk("pd_data", 1'b0, pd);
    @(negedge clk);
    chk("data_fetch", 16'h5A3C, dout);
    rd(32'h00001240, 3'h6, 1'b0);
    @(negedge clk);
    chk("miss_fetch", 16'h5A3C, dout);
    rd(32'h0000123B, 3'h6, 1'b0);
    chk("pd_prog", 1'b1, pd);
    chk("brk_pin0", 1'b1, brk_o & brk_oe);
    @(negedge clk);
    chk("trap", ebu_pkg::TRAP_OPCODE, dout);
    @(negedge clk);
    chk("brk_pin2", 1'b1, brk_o & brk_oe);
    rd(32'h28, 3'h5, 1'b0);
    rd(32'h2A, 3'h5, 1'b0);
    chk("aline_pin", 1'b1, brk_o & brk_oe);
    repeat (2) @(negedge clk);
    chk("aline", 1'b1, stat[1]);
    chk("aline_irq", 1'b1, irq);
    clr(3'h2);
  endtask
  task automatic s_multi;
    @(posedge clk);
    ctl <= 5'b01100;
    amsk <= 32'h0000FFFF;
    lo_cmp <= 16'h1230;
    rd(32'h00001230, 3'h6, 1'b0);
    chk("pin_dir", 1'b0, brk_oe);
    @(negedge clk);
    chk("multi_hit", ebu_pkg::TRAP_OPCODE, dout);
    rd(32'h00001234, 3'h6, 1'b0);
    @(negedge clk);
    chk("ext_miss", 16'h5A3C, dout);
    rd(32'h00011230, 3'h6, 1'b0);
    @(negedge clk);
    chk("int_miss", 16'h5A3C, dout);
  endtask
  // control compare set to data cycles only, so a program read must not match
  task automatic s_bus;
    @(posedge clk);
    ctl <= 5'b10110;
    amsk <= 32'h0;
    cc <= 4'b0010;
    rd(32'h00001230, 3'h6, 1'b0);
    chk("ctl_miss_pin", 1'b0, brk_o);
    repeat (2) @(negedge clk);
    chk("ctl_miss", 1'b0, stat[2]);
    rd(32'h00001230, 3'h5, 1'b0);
    chk("ctl_hit_pin", 1'b1, brk_o);
    repeat (2) @(negedge clk);
    chk("bus_break", 1'b1, stat[2]);
    @(posedge clk);
    ctl <= 5'b10111;
    @(negedge clk);
    chk("vec_hmd", 1'b0, vld);
  endtask
  task automatic s_no_emu;
    rst(1'b0);
    @(negedge clk);
    chk("emu_off", 1'b0, emu);
    @(posedge clk);
    ctl <= 5'b11100;
    rd(32'h0, 3'h6, 1'b1);
    chk("boot_norm", 1'b1, boot_cs);
    rd(32'hFFFC0000, 3'h5, 1'b0);
    chk("mon_off", 1'b0, mon_cs);
    rd(32'h00001230, 3'h6, 1'b0);
    @(negedge clk);
    chk("trap_off", 16'h5A3C, dout);
  endtask
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 4000)
    begin
      n_fail++;
      test_done;
    end
  end
  initial
  begin
    s_boot;
    s_monitor;
    s_pin;
    s_exec;
    s_multi;
    s_bus;
    s_no_emu;
    test_done;
  end
endmodule // emulation_breakpoint_unit_tb

/* File: verilog/ebu_pkg.sv */
// package: constants and carrier types for the emulation breakpoint unit
// Overview of operation
// - capture debug_irq_input at reset release; low selects emulation mode
// - after reset, each falling edge of debug_irq_input raises level seven interrupt
// - in emulation mode keep boot_chip_select deasserted during reset vector fetch
// - emulation reset fetch returns PC 0xFFFC0020 and SSP 0xFFFCFFFC
// - monitor_chip_select covers 0xFFFC0000..0xFFFDFFFF as an 8-bit port
// - monitor region up to 0xFFFCFFFF gets internal acknowledge, data on D[15:8]
// - debug_irq_input high during reset disables the emulation block except the falling-edge level seven interrupt
// - one 32-bit address comparator and one control comparator
// - single mode: breakpoint pin is output, qualified by strobe, whole cycle
// - multiple mode: breakpoint pin is input ANDed with masked internal compare
// - execution breakpoint substitutes opcode 0xA000 at breakpoint location
// - A-line vector fetch after insertion asserts breakpoint signal; single mode only, 0x28 read after its first clock, 0x2A read's first clock
// - vector fetch is reads at 0x28 then 0x2A; only after active insertion
// - program/data indicator low for function code x01, high for x10
// - hard_map_disable clear: level seven vector is 0xFFFC0010
// - each level seven source has a status bit cleared by writing one
// - trap opcode only on instruction fetches matching breakpoint address
// - mask bit one forces its address compare bit to match
package ebu_pkg;
  localparam logic [31:0] RESET_PC = 32'hFFFC0020;
  localparam logic [31:0] RESET_SSP = 32'hFFFCFFFC;
  localparam logic [31:0] MON_BASE = 32'hFFFC0000;
  localparam logic [31:0] MON_LAST = 32'hFFFDFFFF;
  localparam logic [31:0] MON_ACK_LAST = 32'hFFFCFFFF;
  localparam logic [31:0] L7_VECTOR = 32'hFFFC0010;
  localparam logic [15:0] TRAP_OPCODE = 16'hA000;
  localparam logic [31:0] ALINE_VEC_HI = 32'h00000028;
  localparam logic [31:0] ALINE_VEC_LO = 32'h0000002A;
  localparam logic [1:0] FC_DATA = 2'h1;
  localparam logic [1:0] FC_PROG = 2'h2;
  localparam int STAT_W = 3;
  localparam int STAT_EXT = 0;
  localparam int STAT_PROG = 1;
  localparam int STAT_BUS = 2;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] function_code;
    logic rd_wr;    // 1 = read
    logic as_n;
    logic vec_fetch; // reset vector fetch cycle
  } ebu_bus_t;

  typedef struct packed {
    logic single_break_select;
    logic program_break_enable;
    logic compare_enable;
    logic bus_break_irq_enable;
    logic hard_map_disable;
  } ebu_ctrl_t;

  typedef struct packed {
    logic rw_cmp;
    logic pd_cmp;
    logic rw_mask;
    logic pd_mask;
  } ebu_cyc_t;
endpackage

/* File: verilog/ebu_unit.sv */
// module: emulation breakpoint unit logic
`timescale 1ns/1ps
module ebu_unit
(
  input wire logic clk, // 200 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic debug_irq_input, // emulator request pin
  input wire ebu_pkg::ebu_bus_t bus, // core bus cycle
  input wire logic [15:0] core_data, // data arriving toward the core
  input wire ebu_pkg::ebu_ctrl_t emulation_control_reg, // control bits
  input wire logic [31:0] addr_compare_bits, // compare address
  input wire logic [31:0] addr_mask_bits, // 1 = don't care
  input wire ebu_pkg::ebu_cyc_t cyc_cmp, // control compare and mask
  input wire logic [ebu_pkg::STAT_W-1:0] status_w1c, // write one to clear
  input wire logic boot_cs_req, // normal boot select request
  input wire logic breakpoint_signal_i, // pin input level
  output logic breakpoint_signal_o, // pin drive level
  output logic breakpoint_signal_oe, // pin drive enable
  output logic emu_mode, // captured emulation mode
  output logic boot_chip_select, // boot select after gating
  output logic monitor_chip_select, // monitor select
  output logic monitor_port_8bit, // monitor is 8-bit on upper lanes
  output logic monitor_ack, // internal bus acknowledge
  output logic [15:0] data_to_core, // data delivered to the core
  output logic level_seven_interrupt, // level 7 request
  output logic [31:0] l7_vector, // level 7 vector address
  output logic l7_vector_valid, // vector is hard-coded
  output logic [ebu_pkg::STAT_W-1:0] emulation_status_reg, // sticky sources
  output logic program_data // high program, low data
);
  // ---------------------------------------------------------------
  // mode capture and irq pin synchroniser
  // ---------------------------------------------------------------
  logic rst_seen_r;
  logic emu_r;
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  // the pin level must stay out of the async reset; catch it at first edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_seen_r <= 1'b0;
      emu_r <= 1'b0;
    end
    else if (!rst_seen_r)
    begin
      rst_seen_r <= 1'b1;
      emu_r <= ~debug_irq_input;
    end
  end
  assign emu_mode = emu_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
    end
    else if (!rst_seen_r)
    begin
      // preload with the pin so a pin held low through reset is not taken as an edge
      sync1_r <= debug_irq_input;
      sync2_r <= debug_irq_input;
      sync3_r <= debug_irq_input;
    end
    else
    begin
      sync1_r <= debug_irq_input;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  wire irq_fall = rst_seen_r & sync3_r & ~sync2_r;

  // ---------------------------------------------------------------
  // address decode and reset vector
  // ---------------------------------------------------------------
  wire cyc_on = ~bus.as_n;
  wire in_mon = (bus.addr >= ebu_pkg::MON_BASE) && (bus.addr <= ebu_pkg::MON_LAST);
  wire in_ack = (bus.addr >= ebu_pkg::MON_BASE) && (bus.addr <= ebu_pkg::MON_ACK_LAST);
  assign monitor_chip_select = emu_r & cyc_on & in_mon;
  assign monitor_port_8bit = monitor_chip_select;
  assign monitor_ack = emu_r & cyc_on & in_ack;
  assign boot_chip_select = boot_cs_req & ~(emu_r & bus.vec_fetch);
  // reset vector words: 0,2 -> SSP; 4,6 -> PC
  wire [31:0] rv_long = bus.addr[2] ? ebu_pkg::RESET_PC : ebu_pkg::RESET_SSP;
  wire [15:0] rv_word = bus.addr[1] ? rv_long[15:0] : rv_long[31:16];
  assign program_data = bus.function_code[1];

  // ---------------------------------------------------------------
  // breakpoint compare
  // ---------------------------------------------------------------
  wire addr_hit = &((bus.addr ~^ addr_compare_bits) | addr_mask_bits);
  wire is_prog = (bus.function_code[1:0] == ebu_pkg::FC_PROG);
  wire rw_ok = cyc_cmp.rw_mask | (cyc_cmp.rw_cmp == bus.rd_wr);
  wire pd_ok = cyc_cmp.pd_mask | (cyc_cmp.pd_cmp == is_prog);
  wire ext_ok = emulation_control_reg.single_break_select | breakpoint_signal_i;
  wire cmp_on = emu_r & emulation_control_reg.compare_enable & cyc_on;
  wire bus_match = cmp_on & addr_hit & rw_ok & pd_ok & ext_ok;
  wire prog_match = cmp_on & addr_hit & is_prog & ext_ok
    & emulation_control_reg.program_break_enable;
  wire insert = prog_match & bus.rd_wr;

  // ---------------------------------------------------------------
  // A-line vector fetch tracking
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_HI_SEEN} ebu_st_t;
  ebu_st_t st_r;
  ebu_st_t st_nxt;
  logic as_d_r;
  wire cyc_start = cyc_on & as_d_r;
  wire rd_hi = cyc_start & bus.rd_wr & (bus.addr == ebu_pkg::ALINE_VEC_HI);
  wire rd_lo = cyc_start & bus.rd_wr & (bus.addr == ebu_pkg::ALINE_VEC_LO);
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (insert) st_nxt = ST_ARMED;
      ST_ARMED: if (rd_hi) st_nxt = ST_HI_SEEN;
      ST_HI_SEEN:
      begin
        if (rd_lo) st_nxt = ST_IDLE;
        else if (cyc_start) st_nxt = ST_ARMED;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end
  wire aline_hit = (st_r == ST_HI_SEEN) & rd_lo;
  wire in_vec = (st_r == ST_HI_SEEN) & cyc_on;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= ST_IDLE;
      as_d_r <= 1'b1;
    end
    else
    begin
      st_r <= emu_r ? st_nxt : ST_IDLE;
      as_d_r <= bus.as_n;
    end
  end

  // ---------------------------------------------------------------
  // pin drive and data substitution
  // ---------------------------------------------------------------
  assign breakpoint_signal_oe = emu_r & emulation_control_reg.single_break_select;
  assign breakpoint_signal_o = breakpoint_signal_oe & (bus_match | in_vec);
  wire [15:0] mon_data = {core_data[15:8], 8'h00};
  wire [15:0] data_nxt = (emu_r & bus.vec_fetch) ? rv_word
    : insert ? ebu_pkg::TRAP_OPCODE
    : monitor_chip_select ? mon_data : core_data;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      data_to_core <= 16'h0000;
    else
      data_to_core <= data_nxt;
  end

  // ---------------------------------------------------------------
  // level seven sources, set wins over write-one clear
  // ---------------------------------------------------------------
  logic [ebu_pkg::STAT_W-1:0] stat_r;
  logic bus_hit_d_r;
  wire bus_rise = bus_match & ~bus_hit_d_r & emulation_control_reg.bus_break_irq_enable;
  wire [ebu_pkg::STAT_W-1:0] stat_set = {bus_rise, aline_hit, irq_fall};
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stat_r <= '0;
      bus_hit_d_r <= 1'b0;
    end
    else
    begin
      stat_r <= stat_set | (stat_r & ~status_w1c);
      bus_hit_d_r <= bus_match;
    end
  end
  assign emulation_status_reg = stat_r;
  assign level_seven_interrupt = |stat_r;
  assign l7_vector = ebu_pkg::L7_VECTOR;
  assign l7_vector_valid = ~emulation_control_reg.hard_map_disable;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_mode_capture: assert property (@(posedge clk) disable iff (!nrst)
    $rose(rst_seen_r) |-> emu_r == ~$past(debug_irq_input))
    else $error("mode not captured from pin");
  a_irq_edge: assert property (@(posedge clk) disable iff (!nrst)
    (rst_seen_r && $fell(debug_irq_input)) |-> ##3 stat_r[ebu_pkg::STAT_EXT])
    else $error("falling edge lost");
  a_boot_gated: assert property (@(posedge clk) disable iff (!nrst)
    (emu_r && bus.vec_fetch) |-> !boot_chip_select)
    else $error("boot select during emulation vector fetch");
  a_reset_vec: assert property (@(posedge clk) disable iff (!nrst)
    (emu_r && bus.vec_fetch && bus.addr[2:1] == 2'h2) |=> data_to_core == 16'hFFFC)
    else $error("wrong reset PC high word");
  a_mon_select: assert property (@(posedge clk) disable iff (!nrst)
    monitor_chip_select |-> (bus.addr[31:17] == 15'h7FFE) && emu_r)
    else $error("monitor select outside region");
  a_mon_ack: assert property (@(posedge clk) disable iff (!nrst)
    monitor_ack |-> monitor_chip_select && bus.addr[16] == 1'b0)
    else $error("ack outside 64K monitor");
  a_disabled: assert property (@(posedge clk) disable iff (!nrst)
    !emu_r |-> !monitor_chip_select && !breakpoint_signal_oe && st_r == ST_IDLE)
    else $error("emulation logic active while disabled");
  a_trap_insert: assert property (@(posedge clk) disable iff (!nrst)
    (insert && !bus.vec_fetch) |=> data_to_core == 16'hA000)
    else $error("trap opcode not inserted");
  a_bkpt_pin: assert property (@(posedge clk) disable iff (!nrst)
    breakpoint_signal_o |-> cyc_on && emulation_control_reg.single_break_select)
    else $error("breakpoint pin outside strobe");
  a_aline_order: assert property (@(posedge clk) disable iff (!nrst)
    $rose(stat_r[ebu_pkg::STAT_PROG]) |-> $past(st_r) == ST_HI_SEEN)
    else $error("program hit without vector fetch pair");
  a_pd_pin: assert property (@(posedge clk) disable iff (!nrst)
    (bus.function_code[1:0] == ebu_pkg::FC_DATA) |-> !program_data)
    else $error("data cycle shown as program");
endmodule // ebu_unit
